/* serial_unit.v */
`include "serial_unit_defines.vh"
`default_nettype none

module serial_unit (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Serial pins
   input wire rxd_in,
   output reg txd_out,
   input wire sck_in,
   output reg sck_out,
   output reg sck_oe,
   // Interrupt requests
   output reg rx_fault_irq,
   output reg rx_full_irq,
   output reg tx_empty_irq,
   output reg tx_done_irq,
   output reg [1:0] top_irq_code
);

   // ************************************************
   // Registers and state
   // ************************************************
   reg [7:0] serial_ctrl_reg;
   reg [7:0] mode_r;
   reg [7:0] div_r;
   reg [7:0] tx_holding_reg;
   reg [7:0] rx_holding_reg;
   reg [7:0] rx_shifter;
   reg [7:0] tx_shifter;
   reg rx_full_flag, overrun_flag, framing_error_flag, parity_error_flag;
   reg tx_holding_empty_flag, tx_done_flag;
   reg [1:0] rxd_sync, sck_sync;
   reg sck_prev;
   reg [7:0] div_cnt;
   reg tick;
   // Clocked-mode engine
   reg sync_busy, sync_half;
   reg [3:0] sync_bits;
   reg tx_active;
   // Async receiver
   reg [3:0] os_cnt;
   reg [3:0] a_bits;
   reg a_busy, a_par;
   reg a_parbit_phase, a_stop_phase;
   reg a_rx_prev;
   // Async transmitter
   reg [3:0] at_os;
   reg [3:0] at_bits;
   reg at_busy;

   wire rx_on = serial_ctrl_reg[`CTRL_RX_ON];
   wire tx_on = serial_ctrl_reg[`CTRL_TX_ON];
   wire sync_mode = mode_r[`MODE_SYNC];
   wire clk_out = mode_r[`MODE_CLK_OUT];
   wire any_err = overrun_flag | framing_error_flag | parity_error_flag;
   wire rxd = rxd_sync[1];
   wire sck_s = sck_sync[1];
   wire ext_rise = sync_mode & ~clk_out & sck_s & ~sck_prev;
   wire ext_fall = sync_mode & ~clk_out & ~sck_s & sck_prev;
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;

   // Status byte assembly, used for status reads
   function [7:0] status_byte;
      input f_tde, f_full, f_ov, f_fe, f_pe, f_done;
      begin
         status_byte = `BYTE_ZERO;
         status_byte[`ST_TX_EMPTY] = f_tde;
         status_byte[`ST_RX_FULL] = f_full;
         status_byte[`ST_OVERRUN] = f_ov;
         status_byte[`ST_FRAMING_ERR] = f_fe;
         status_byte[`ST_PARITY_ERR] = f_pe;
         status_byte[`ST_TX_DONE] = f_done;
      end
   endfunction

   // ************************************************
   // Pin synchronisers and baud divider
   // ************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_sync <= 2'b11;
         sck_sync <= 2'b11;
         sck_prev <= 1'b1;
         div_cnt <= `BYTE_ZERO;
         tick <= 1'b0;
      end else begin
         rxd_sync <= {rxd_sync[0], rxd_in};
         sck_sync <= {sck_sync[0], sck_in};
         sck_prev <= sck_s;
         // Tick is 16x bit rate in async, half bit in clocked output mode
         if (div_cnt == div_r) begin
            div_cnt <= `BYTE_ZERO;
            tick <= 1'b1;
         end else begin
            div_cnt <= div_cnt + 8'h01;
            tick <= 1'b0;
         end
      end
   end

   // ************************************************
   // APB slave: zero wait states, unmapped gives error
   // ************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Ready answers in the first access cycle
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            pslverr <= (paddr > `OFS_DIV) | (paddr[1:0] != 2'b00);
            case (paddr)
               `OFS_CTRL: prdata <= {24'h000000, serial_ctrl_reg};
               `OFS_MODE: prdata <= {24'h000000, mode_r};
               `OFS_STATUS: prdata <= {24'h000000, status_byte(tx_holding_empty_flag,
                  rx_full_flag, overrun_flag, framing_error_flag, parity_error_flag,
                  tx_done_flag)};
               `OFS_TXDATA: prdata <= {24'h000000, tx_holding_reg};
               `OFS_RXDATA: prdata <= {24'h000000, rx_holding_reg};
               `OFS_IRQ: prdata <= {24'h000000, 2'b00, top_irq_code, rx_fault_irq,
                  rx_full_irq, tx_empty_irq, tx_done_irq};
               `OFS_DIV: prdata <= {24'h000000, div_r};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************
   // Control, data and flags
   // ************************************************
   reg char_done;
   reg char_fe, char_pe;
   reg tx_load;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_ctrl_reg <= `CTRL_RESET;
         mode_r <= `MODE_RESET;
         div_r <= `DIV_RESET;
         tx_holding_reg <= `BYTE_ZERO;
         rx_holding_reg <= `BYTE_ZERO;
         rx_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
         framing_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         tx_holding_empty_flag <= 1'b1;
         tx_done_flag <= 1'b1;
      end else begin
         if (wr && paddr == `OFS_CTRL)
            serial_ctrl_reg <= pwdata[7:0];
         if (wr && paddr == `OFS_MODE)
            mode_r <= pwdata[7:0];
         if (wr && paddr == `OFS_DIV)
            div_r <= pwdata[7:0];
         if (wr && paddr == `OFS_TXDATA)
            tx_holding_reg <= pwdata[7:0];
         // software-only clear: write 0 to a flag bit clears it; bit 7 clears TX empty and TX done, bit 2 clears nothing
         if (wr && paddr == `OFS_STATUS) begin
            if (!pwdata[`ST_RX_FULL]) rx_full_flag <= 1'b0;
            if (!pwdata[`ST_OVERRUN]) overrun_flag <= 1'b0;
            if (!pwdata[`ST_FRAMING_ERR]) framing_error_flag <= 1'b0;
            if (!pwdata[`ST_PARITY_ERR]) parity_error_flag <= 1'b0;
            if (!pwdata[`ST_TX_EMPTY]) begin
               tx_holding_empty_flag <= 1'b0;
               tx_done_flag <= 1'b0;
            end
         end
         if (tx_load)
            tx_holding_empty_flag <= 1'b1;
         if (tx_active && !tx_load && !sync_busy && !at_busy)
            tx_done_flag <= 1'b1;
         // load or overrun, nothing while an error stands; set wins
         if (char_done && !any_err) begin
            if (rx_full_flag && !(wr && paddr == `OFS_STATUS &&
                  !pwdata[`ST_RX_FULL])) begin
               overrun_flag <= 1'b1;
               if (char_fe) framing_error_flag <= 1'b1;
               if (char_pe) parity_error_flag <= 1'b1;
            end else begin
               rx_holding_reg <= rx_shifter;
               // break gives framing error with zero data
               if (char_fe | char_pe) begin
                  framing_error_flag <= framing_error_flag | char_fe;
                  parity_error_flag <= parity_error_flag | char_pe;
               end else
                  rx_full_flag <= 1'b1;
            end
         end
      end
   end

   // ************************************************
   // Receive and transmit engines
   // ************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shifter <= `BYTE_ZERO;
         tx_shifter <= `BYTE_ZERO;
         txd_out <= 1'b1;
         sck_out <= 1'b1;
         sck_oe <= 1'b0;
         sync_busy <= 1'b0;
         sync_half <= 1'b0;
         sync_bits <= 4'h0;
         tx_active <= 1'b0;
         os_cnt <= 4'h0;
         a_bits <= 4'h0;
         a_busy <= 1'b0;
         a_par <= 1'b0;
         a_parbit_phase <= 1'b0;
         a_stop_phase <= 1'b0;
         a_rx_prev <= 1'b1;
         at_os <= 4'h0;
         at_bits <= 4'h0;
         at_busy <= 1'b0;
         char_done <= 1'b0;
         char_fe <= 1'b0;
         char_pe <= 1'b0;
         tx_load <= 1'b0;
      end else begin
         char_done <= 1'b0;
         char_fe <= 1'b0;
         char_pe <= 1'b0;
         tx_load <= 1'b0;
         sck_oe <= sync_mode & clk_out;
         if (sync_mode) begin
            // errors block start of any character
            if (!sync_busy && !any_err && !tx_load) begin
               if (tx_on && !tx_holding_empty_flag) begin
                  tx_shifter <= tx_holding_reg;
                  tx_load <= 1'b1;
                  tx_active <= 1'b1;
                  sync_busy <= 1'b1;
                  txd_out <= tx_holding_reg[0];
               // receive start, resumes once overrun cleared
               end else if (rx_on && !tx_on && clk_out) begin
                  sync_busy <= 1'b1;
                  tx_active <= 1'b0;
               end else if (rx_on && !clk_out) begin
                  sync_busy <= 1'b1;
                  tx_active <= 1'b0;
               end
               sync_bits <= 4'h0;
               sync_half <= 1'b0;
               sck_out <= 1'b1;
            end else if (sync_busy) begin
               // stop output clock on receive-off while no send is active, or on overrun
               if (clk_out && ((!rx_on && !tx_active) || overrun_flag)) begin
                  sync_busy <= 1'b0;
                  sck_out <= 1'b1;
               end else if ((clk_out && tick && !sync_half) || ext_fall) begin
                  sck_out <= ~clk_out;
                  sync_half <= 1'b1;
                  if (sync_bits != 4'h0)
                     txd_out <= tx_shifter[0];
               end else if ((clk_out && tick && sync_half) || ext_rise) begin
                  sck_out <= 1'b1;
                  sync_half <= 1'b0;
                  rx_shifter <= {rxd, rx_shifter[7:1]};
                  tx_shifter <= {1'b1, tx_shifter[7:1]};
                  sync_bits <= sync_bits + 4'h1;
                  if (sync_bits == `LAST_BIT) begin
                     sync_busy <= 1'b0;
                     char_done <= rx_on;
                  end
               end
            end
         end else begin
            sck_out <= 1'b1;
            sync_busy <= 1'b0;
            // start detected on falling edge at 16x rate
            if (tick) begin
               // History frozen while an error blocks starts, so a break restarts later
               if (a_busy || !any_err)
                  a_rx_prev <= rxd;
               if (!a_busy) begin
                  if (rx_on && !any_err && a_rx_prev && !rxd) begin
                     a_busy <= 1'b1;
                     os_cnt <= 4'h0;
                     a_bits <= 4'h0;
                     a_par <= 1'b0;
                     a_parbit_phase <= 1'b0;
                     a_stop_phase <= 1'b0;
                  end
               end else begin
                  os_cnt <= os_cnt + 4'h1;
                  if (os_cnt == `HALF_BIT) begin
                     if (a_stop_phase) begin
                        a_busy <= 1'b0;
                        // Frame boundary: a low line after it counts as a new start
                        a_rx_prev <= 1'b1;
                        char_done <= 1'b1;
                        char_fe <= ~rxd;
                        char_pe <= mode_r[`MODE_PARITY_EN] &
                           (a_par ^ mode_r[`MODE_PARITY_ODD]);
                     end else if (a_parbit_phase) begin
                        a_par <= a_par ^ rxd;
                        a_stop_phase <= 1'b1;
                     end else if (a_bits != 4'h0) begin
                        rx_shifter <= {rxd, rx_shifter[7:1]};
                        a_par <= a_par ^ rxd;
                        if (a_bits == `BITS_PER_CHAR) begin
                           a_parbit_phase <= mode_r[`MODE_PARITY_EN];
                           a_stop_phase <= ~mode_r[`MODE_PARITY_EN];
                        end
                     end else if (rxd)
                        a_busy <= 1'b0;
                     a_bits <= a_bits + 4'h1;
                  end
               end
               // Async transmitter: start, 8 data, stop
               if (!at_busy) begin
                  txd_out <= 1'b1;
                  if (tx_on && !any_err && !tx_holding_empty_flag && !tx_load) begin
                     tx_shifter <= tx_holding_reg;
                     tx_load <= 1'b1;
                     tx_active <= 1'b1;
                     at_busy <= 1'b1;
                     at_os <= 4'h0;
                     at_bits <= 4'h0;
                     txd_out <= 1'b0;
                  end
               end else begin
                  at_os <= at_os + 4'h1;
                  if (at_os == `OVERSAMPLE) begin
                     at_bits <= at_bits + 4'h1;
                     if (at_bits == `BITS_PER_CHAR) begin
                        at_busy <= 1'b0;
                        txd_out <= 1'b1;
                     end else begin
                        txd_out <= (at_bits == `LAST_BIT + 4'h1) ? 1'b1 : tx_shifter[0];
                        tx_shifter <= {1'b1, tx_shifter[7:1]};
                     end
                  end
               end
            end
         end
         if (tx_active && !sync_busy && !at_busy && tx_holding_empty_flag && !tx_load)
            tx_active <= 1'b0;
      end
   end

   // ************************************************
   // Interrupt requests
   // ************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_fault_irq <= 1'b0;
         rx_full_irq <= 1'b0;
         tx_empty_irq <= 1'b0;
         tx_done_irq <= 1'b0;
         top_irq_code <= 2'b00;
      end else begin
         // fault request ORs the three errors
         rx_fault_irq <= serial_ctrl_reg[`CTRL_RX_IRQ_EN] & any_err;
         rx_full_irq <= serial_ctrl_reg[`CTRL_RX_IRQ_EN] & rx_full_flag;
         tx_empty_irq <= serial_ctrl_reg[`CTRL_TX_IRQ_EN] & tx_holding_empty_flag;
         tx_done_irq <= serial_ctrl_reg[`CTRL_TX_DONE_IRQ_EN] & tx_done_flag;
         if (serial_ctrl_reg[`CTRL_RX_IRQ_EN] & any_err)
            top_irq_code <= 2'b00;
         else if (serial_ctrl_reg[`CTRL_RX_IRQ_EN] & rx_full_flag)
            top_irq_code <= 2'b01;
         else if (serial_ctrl_reg[`CTRL_TX_IRQ_EN] & tx_holding_empty_flag)
            top_irq_code <= 2'b10;
         else
            top_irq_code <= 2'b11;
      end
   end

endmodule // serial_unit

`default_nettype wire

/* serial_unit_defines.vh */
`ifndef SERIAL_UNIT_DEFINES_VH
`define SERIAL_UNIT_DEFINES_VH
// APB register byte offsets
`define OFS_CTRL 12'h000
`define OFS_MODE 12'h004
`define OFS_STATUS 12'h008
`define OFS_TXDATA 12'h00C
`define OFS_RXDATA 12'h010
`define OFS_IRQ 12'h014
// Control register bits
`define CTRL_TX_ON 2
`define CTRL_RX_ON 3
`define CTRL_TX_DONE_IRQ_EN 4
`define CTRL_RX_IRQ_EN 5
`define CTRL_TX_IRQ_EN 6
// Mode register bits
`define MODE_SYNC 0
`define MODE_CLK_OUT 1
`define MODE_PARITY_EN 2
`define MODE_PARITY_ODD 3
// Status register bits
`define ST_TX_DONE 2
`define ST_PARITY_ERR 3
`define ST_FRAMING_ERR 4
`define ST_OVERRUN 5
`define ST_RX_FULL 6
`define ST_TX_EMPTY 7
// Reset values
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define DIV_RESET 8'h0F
`define BYTE_ZERO 8'h00
// Counts and register offsets
`define BITS_PER_CHAR 4'h8
`define OVERSAMPLE 4'hF
`define HALF_BIT 4'h7
`define LAST_BIT 4'h7
`define APB_ERR_OFS 12'h018
`define OFS_DIV 12'h018
`endif

/* serial_unit_assertions.sv */
`include "serial_unit_defines.vh"
`default_nettype none
// ****************************************
// Port checker for the serial unit
// ****************************************
module serial_unit_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Serial clock
   input wire logic sck_out,
   input wire logic sck_oe,
   // Requests
   input wire logic rx_fault_irq,
   input wire logic rx_full_irq,
   input wire logic [1:0] top_irq_code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Any completed write, the only thing allowed to drop a flag
   wire bus_wr = psel && penable && pwrite;

   chk_sck_idle: assert property (!sck_oe && !$past(sck_oe) |-> sck_out)
      else $error("serial clock not parked high");
   chk_ready_next: assert property (psel && !penable |=> pready)
      else $error("no answer in first access cycle");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_bad_addr: assert property (pready && (paddr > `OFS_DIV || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("bad address not refused");
   chk_good_addr: assert property (pready && paddr <= `OFS_DIV && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("good address refused");
   chk_fault_first: assert property (rx_fault_irq && $past(rx_fault_irq) |-> top_irq_code == 2'h0)
      else $error("fault request not on top");
   chk_full_next: assert property (rx_full_irq && $past(rx_full_irq) && !rx_fault_irq
      && !$past(rx_fault_irq) |-> top_irq_code == 2'h1)
      else $error("full request not ranked second");
   chk_fault_sticky: assert property ($fell(rx_fault_irq) |-> $past(bus_wr) || $past(bus_wr, 2))
      else $error("fault request dropped without a write");
   chk_full_sticky: assert property ($fell(rx_full_irq) |-> $past(bus_wr) || $past(bus_wr, 2))
      else $error("full request dropped without a write");
   // Main scenarios
   cover property ($rose(rx_full_irq));
   cover property ($rose(rx_fault_irq));
   cover property (pready && pslverr);
endmodule // serial_unit_assertions
`default_nettype wire

/* serial_partner.sv */
`default_nettype none
// ****************************************
// Far-side serial device
// ****************************************
module serial_partner (
   // Clock from the unit
   input wire logic sck_out,
   input wire logic sck_oe,
   // Lines towards the unit
   output logic sck_in,
   output logic rxd_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] obyte;
   int nbit;
   int npulse;
   // Idle: clock parked high, line high
   initial begin
      sck_in = 1'b1;
      rxd_in = 1'b1;
      obyte = 8'h00;
      nbit = 0;
      npulse = 0;
   end
   task automatic send_ext(input logic [7:0] b);
      #7;
      for (int i = 0; i < 8; i++) begin
         sck_in = 1'b0;
         rxd_in = b[i];
         #80;
         sck_in = 1'b1;
         #80;
      end
      #40;
      rxd_in = ~b[7]; // Hold time over, so no stale bit shows
   endtask
   // Steady level, used for idle and break
   task automatic set_line(input logic v);
      rxd_in <= v;
   endtask
   always @(negedge sck_out) begin
      if (sck_oe) begin
         rxd_in <= obyte[nbit];
         nbit <= (nbit + 1) % 8;
         npulse <= npulse + 1;
      end
   end
endmodule // serial_partner
`default_nettype wire

/* serial_unit_tb.sv */
`include "serial_unit_defines.vh"
`default_nettype none
`define CHK(got, exp) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end
// ****************************************
// Serial unit bench
// ****************************************
module serial_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sck_in, sck_out, sck_oe, rxd_in, txd_out;
   logic rx_fault_irq, rx_full_irq, tx_empty_irq, tx_done_irq;
   logic [1:0] top_irq_code;
   logic [7:0] b;
   int fail_count, compares, seed, m_full, m_ovr, m_fe, p0;
   logic [7:0] m_data;

   serial_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd_in(rxd_in), .txd_out(txd_out), .sck_in(sck_in), .sck_out(sck_out),
      .sck_oe(sck_oe), .rx_fault_irq(rx_fault_irq), .rx_full_irq(rx_full_irq),
      .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .top_irq_code(top_irq_code));
   serial_partner p (.sck_out(sck_out), .sck_oe(sck_oe), .sck_in(sck_in), .rxd_in(rxd_in));

   // 50 MHz clock
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   // One bus transfer, held until ready is seen
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      if (k >= 20) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd & m, e)
   endtask
   // Poll status until a flag shows, then let the line settle
   task automatic wait_flag(input logic [31:0] m);
      int k;
      k = 0;
      do begin
         apb(1'b0, `OFS_STATUS, 32'h0);
         k++;
      end while ((rd & m) == 0 && k < 1000);
      if (k >= 1000) fail_count++;
      repeat (64) @(posedge pclk);
   endtask
   // Clear flags by writing zeros; bit 7 kept so no send starts
   task automatic clr(input logic [31:0] v);
      apb(1'b1, `OFS_STATUS, v);
      m_full = 0;
      m_ovr = 0;
   endtask
   function automatic logic [31:0] st_exp();
      return {25'h0, m_full[0], m_ovr[0], m_fe[0], 4'h0};
   endfunction
   task automatic model_char(input logic [7:0] c);
      if (m_ovr == 0 && m_fe == 0) begin
         if (m_full != 0) m_ovr = 1;
         else begin
            m_full = 1;
            m_data = c;
         end
      end
   endtask

   task automatic stop_test();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard
   initial begin
      #1000000;
      fail_count++;
      stop_test();
   end

   // Main sequence
   initial begin
      seed = 67;
      fail_count = 0;
      compares = 0;
      m_full = 0;
      m_ovr = 0;
      m_fe = 0;
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(sck_out, 1'b1)
      rd_chk(`OFS_DIV, 32'hFFFFFFFF, {24'h0, `DIV_RESET});
      rd_chk(12'h01C, 32'hFFFFFFFF, 32'h0);
      `CHK(err, 1'b1)
      // Transmit-side requests and holding-register overwrite
      apb(1'b1, `OFS_CTRL, 32'h50);
      apb(1'b1, `OFS_TXDATA, 32'hA5);
      apb(1'b1, `OFS_TXDATA, 32'h3C);
      rd_chk(`OFS_TXDATA, 32'hFF, 32'h3C);
      `CHK(tx_empty_irq, 1'b1)
      `CHK(tx_done_irq, 1'b1)
      `CHK(top_irq_code, 2'h2)
      // Partner supplies the clock; overrun, blocking and recovery
      apb(1'b1, `OFS_MODE, 32'h01);
      apb(1'b1, `OFS_CTRL, 32'h28);
      for (int i = 0; i < 6; i++) begin
         if (i == 4) clr(32'h9F);
         b = 8'($random(seed));
         p.send_ext(b);
         model_char(b);
         repeat (8) @(posedge pclk);
         rd_chk(`OFS_STATUS, 32'h70, st_exp());
         rd_chk(`OFS_RXDATA, 32'hFF, {24'h0, m_data});
         `CHK(rx_full_irq, 1'b1)
         `CHK(rx_fault_irq, m_ovr[0])
         `CHK(top_irq_code, (m_ovr != 0) ? 2'h0 : 2'h1)
      end
      // Unit drives the clock; dummy char forces the halt
      // enables cleared before a new setting
      apb(1'b1, `OFS_CTRL, 32'h00);
      clr(32'h87);
      p.obyte = 8'($random(seed));
      p0 = p.npulse;
      apb(1'b1, `OFS_MODE, 32'h03);
      // Enable is registered one cycle after the mode write lands
      @(posedge pclk);
      `CHK(sck_oe, 1'b1)
      apb(1'b1, `OFS_CTRL, 32'h08);
      wait_flag(32'h20);
      `CHK(p.npulse - p0, 16)
      `CHK(rx_full_irq, 1'b0)
      rd_chk(`OFS_RXDATA, 32'hFF, {24'h0, p.obyte});
      p.obyte = 8'($random(seed));
      clr(32'h9F);
      wait_flag(32'h20);
      `CHK(p.npulse - p0, 32)
      rd_chk(`OFS_RXDATA, 32'hFF, {24'h0, p.obyte});
      // Asynchronous line held low; idle high first so the start edge shows
      p.set_line(1'b1);
      apb(1'b1, `OFS_CTRL, 32'h00);
      apb(1'b1, `OFS_MODE, 32'h00);
      apb(1'b1, `OFS_DIV, 32'h01);
      clr(32'h87);
      apb(1'b1, `OFS_CTRL, 32'h28);
      p.set_line(1'b0);
      for (int i = 0; i < 2; i++) begin
         wait_flag(32'h10);
         rd_chk(`OFS_STATUS, 32'h70, 32'h10);
         rd_chk(`OFS_RXDATA, 32'hFF, 32'h0);
         `CHK(rx_fault_irq, 1'b1)
         // Error stands: a queued byte must not go out
         if (i == 0) begin
            apb(1'b1, `OFS_CTRL, 32'h2C);
            apb(1'b1, `OFS_STATUS, 32'h7F);
            repeat (40) @(posedge pclk);
            `CHK(txd_out, 1'b1)
            rd_chk(`OFS_STATUS, 32'h80, 32'h0);
         end
         apb(1'b1, `OFS_STATUS, 32'hEF);
      end
      stop_test();
   end
endmodule // serial_unit_tb

bind serial_unit serial_unit_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .sck_out(sck_out), .sck_oe(sck_oe), .rx_fault_irq(rx_fault_irq),
   .rx_full_irq(rx_full_irq), .top_irq_code(top_irq_code));
`default_nettype wire
